// File: dv/pattern_sequencer_bench.sv
// Self-checking bench for the pattern sequencer and its memory-side watcher.
`timescale 1ns/1ps
`default_nettype none
module pattern_sequencer_bench;
  typedef struct packed {
    logic [5:0] ptr;
    logic [3:0] sel;
    logic [1:0] lo;
    logic [1:0] hi;
    logic [19:0] fill;
    logic [1:0] div;
    logic [1:0] bank;
    logic dflt;
  } row_type;
  localparam row_type ROWS [0:4] = '{
    '{6'h00, 4'h5, 2'h3, 2'h2, 20'hABCDE, 2'h2, 2'h0, 1'b1},
    '{6'h3F, 4'h2, 2'h2, 2'h3, 20'h12345, 2'h1, 2'h1, 1'b0},
    '{6'h17, 4'h3, 2'h0, 2'h1, 20'hFFFFF, 2'h3, 2'h2, 1'b0},
    '{6'h2A, 4'h6, 2'h1, 2'h0, 20'h0F0F0, 2'h0, 2'h3, 1'b1},
    '{6'h08, 4'h9, 2'h3, 2'h3, 20'h55555, 2'h1, 2'h3, 1'b1}
  };
  logic clk_in = 1'b0;
  logic arst_n_in, mode_write_in, mode_line_zero_in, transfer_write_in;
  logic txn_valid_in, txn_write_in, general_line_zero_out, busy_out, txn_done_out;
  logic [1:0] mode_command_in, bus_divider_field_in, machine_command_field_out;
  logic [5:0] mode_pointer_in, ram_word_pointer_out;
  logic [31:0] transfer_data_in, txn_addr_in, ram_word_transfer_reg_out, select_trace;
  logic [3:0][15:0] bank_base_in, bank_mask_in;
  logic [3:0] bank_assigned_in, local_chip_select_n_out;
  logic [7:0] line_trace;
  logic multi_select;
  int err_count = 0;
  int checks = 0;
  always #4 clk_in = ~clk_in;
  pattern_sequencer pattern_sequencer_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .mode_write_in(mode_write_in), .mode_command_in(mode_command_in),
    .mode_pointer_in(mode_pointer_in), .mode_line_zero_in(mode_line_zero_in),
    .transfer_write_in(transfer_write_in), .transfer_data_in(transfer_data_in),
    .bus_divider_field_in(bus_divider_field_in), .bank_base_in(bank_base_in),
    .bank_mask_in(bank_mask_in), .bank_assigned_in(bank_assigned_in),
    .txn_valid_in(txn_valid_in), .txn_write_in(txn_write_in), .txn_addr_in(txn_addr_in),
    .machine_command_field_out(machine_command_field_out),
    .ram_word_pointer_out(ram_word_pointer_out),
    .ram_word_transfer_reg_out(ram_word_transfer_reg_out),
    .local_chip_select_n_out(local_chip_select_n_out),
    .general_line_zero_out(general_line_zero_out), .busy_out(busy_out),
    .txn_done_out(txn_done_out));
  select_watch_model select_watch_model_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .select_n_in(local_chip_select_n_out), .line_zero_in(general_line_zero_out),
    .select_trace_out(select_trace), .line_trace_out(line_trace),
    .multi_select_out(multi_select));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic set_mode(input logic [1:0] cmd, input logic [5:0] ptr, input logic dflt);
    @(posedge clk_in);
    mode_write_in <= 1'b1;
    mode_command_in <= cmd;
    mode_pointer_in <= ptr;
    mode_line_zero_in <= dflt;
    @(posedge clk_in);
    mode_write_in <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic set_xfer(input logic [31:0] w);
    @(posedge clk_in);
    transfer_write_in <= 1'b1;
    transfer_data_in <= w;
    @(posedge clk_in);
    transfer_write_in <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic run_txn(input logic wr, input logic [1:0] bank, input logic [1:0] div,
                         input logic exp_done);
    logic seen;
    seen = 1'b0;
    @(posedge clk_in);
    txn_valid_in <= 1'b1;
    txn_write_in <= wr;
    txn_addr_in <= {4'(bank) + 4'h1, 28'h0001234};
    bus_divider_field_in <= div;
    @(posedge clk_in);
    txn_valid_in <= 1'b0;
    #1;
    check(32'(busy_out), 32'(exp_done));
    for (int i = 0; i < 24 && !seen; i++) begin
      @(posedge clk_in);
      #1;
      seen = (txn_done_out === 1'b1);
    end
    check(32'(seen), 32'(exp_done));
  endtask
  task automatic reset_values();
    check(32'(local_chip_select_n_out), 32'hF);
    check(32'(general_line_zero_out), 32'h1);
    check(32'(ram_word_pointer_out), 32'h0);
    check(32'(machine_command_field_out), 32'h0);
    check(ram_word_transfer_reg_out, 32'h0);
    check(32'(busy_out), 32'h0);
  endtask
  function automatic logic [3:0] nib(input logic v, input logic [1:0] bank);
    logic [3:0] n;
    n = 4'hF;
    n[bank] = v;
    return n;
  endfunction
  function automatic logic lvl(input logic [1:0] code, input logic dflt);
    return (code == 2'h2) ? 1'b0 : ((code == 2'h3) ? 1'b1 : dflt);
  endfunction
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    row_type r;
    logic [31:0] w, sexp;
    logic [7:0] lexp;
    int n, q;
    {arst_n_in, mode_write_in, mode_line_zero_in, transfer_write_in} = 4'h0;
    {txn_valid_in, txn_write_in, mode_command_in, mode_pointer_in} = 10'h000;
    {transfer_data_in, txn_addr_in} = 64'h0;
    bank_base_in = {16'h4000, 16'h3000, 16'h2000, 16'h1000};
    bank_mask_in = {4{16'hF000}};
    bank_assigned_in = 4'hF;
    bus_divider_field_in = 2'h2;
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    reset_values();
    foreach (ROWS[i]) begin
      r = ROWS[i];
      w = {r.sel, 4'h0, r.lo, r.hi, r.fill};
      set_mode(2'h1, r.ptr, r.dflt);
      set_xfer(w);
      check(ram_word_transfer_reg_out, w);
      run_txn(1'b1, r.bank, 2'h2, 1'b1);
      check(32'(ram_word_pointer_out), 32'(6'(r.ptr + 6'h01)));
      check(select_trace, 32'hFFFFFFFF);
      check(32'(line_trace), 32'({8{r.dflt}}));
    end
    foreach (ROWS[i]) begin
      r = ROWS[i];
      w = {r.sel, 4'h0, r.lo, r.hi, r.fill};
      set_xfer(~w);
      set_mode(2'h2, r.ptr, r.dflt);
      check(32'(machine_command_field_out), 32'h2);
      run_txn(1'b0, r.bank, 2'h2, 1'b1);
      check(32'(ram_word_pointer_out), 32'(6'(r.ptr + 6'h01)));
      check(ram_word_transfer_reg_out, w);
      set_mode(2'h0, r.ptr, r.dflt);
      run_txn(1'b0, r.bank, r.div, 1'b1);
      check(32'(ram_word_pointer_out), 32'(r.ptr));
      sexp = 32'hFFFFFFFF;
      lexp = {8{r.dflt}};
      n = (r.div == 2'h1) ? 2 : ((r.div == 2'h3) ? 8 : 4);
      for (int k = 0; k < n; k++) begin
        q = k * 4 / n;
        sexp = {sexp[27:0], nib(r.sel[3-q], r.bank)};
        lexp = {lexp[6:0], lvl((q < 2) ? r.lo : r.hi, r.dflt)};
      end
      check(select_trace, sexp);
      check(32'(line_trace), 32'(lexp));
    end
    check(32'(multi_select), 32'h0);
    set_mode(2'h1, 6'h10, 1'b1);
    run_txn(1'b0, 2'h0, 2'h2, 1'b1);
    check(32'(ram_word_pointer_out), 32'h10);
    @(posedge clk_in);
    bank_assigned_in <= 4'h7;
    set_mode(2'h0, 6'h00, 1'b1);
    run_txn(1'b0, 2'h3, 2'h2, 1'b0);
    check(select_trace, 32'hFFFFFFFF);
    @(posedge clk_in);
    bank_assigned_in <= 4'hF;
    // The run command plays the word at the pointer once, as a normal access does.
    set_mode(2'h3, 6'h08, 1'b1);
    run_txn(1'b1, 2'h3, 2'h1, 1'b1);
    check(select_trace, 32'hFFFFFFF7);
    check(32'(line_trace), 32'hFF);
    check(32'(ram_word_pointer_out), 32'h08);
    @(posedge clk_in);
    txn_valid_in <= 1'b1;
    txn_addr_in <= 32'h10001234;
    @(posedge clk_in);
    txn_valid_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b0;
    #1;
    reset_values();
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    reset_values();
    set_mode(2'h1, 6'h05, 1'b1);
    run_txn(1'b1, 2'h0, 2'h2, 1'b1);
    check(32'(ram_word_pointer_out), 32'h06);
    complete_run();
  end
endmodule
`default_nettype wire

// File: dv/select_watch_model.sv
// Memory-side watcher that records the select and line zero levels seen each cycle.
`timescale 1ns/1ps
`default_nettype none
module select_watch_model (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] select_n_in,
  input wire logic line_zero_in,
  output logic [31:0] select_trace_out,
  output logic [7:0] line_trace_out,
  output logic multi_select_out
);
  // A device sees the pins every cycle, so the last eight cycles are kept.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      select_trace_out <= 32'hFFFFFFFF;
      line_trace_out <= 8'hFF;
      multi_select_out <= 1'b0;
    end else begin
      select_trace_out <= {select_trace_out[27:0], select_n_in};
      line_trace_out <= {line_trace_out[6:0], line_zero_in};
      if ($countones(~select_n_in) > 1) begin
        multi_select_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: include/sequencer_pkg.sv
// Constants shared by the pattern sequencer and its pattern store.
package sequencer_pkg;
  localparam int RAM_DEPTH = 64;
  localparam int RAM_WIDTH = 32;
  localparam int PTR_WIDTH = 6;
  localparam int NUM_BANKS = 4;
  localparam int ADDR_WIDTH = 32;
  localparam int BANK_WIDTH = 16;
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_RUN = 2'h3;
  localparam logic [1:0] DIV_TWO = 2'h1;
  localparam logic [1:0] DIV_FOUR = 2'h2;
  localparam logic [1:0] DIV_EIGHT = 2'h3;
  localparam logic [2:0] LAST_TICK_TWO = 3'h1;
  localparam logic [2:0] LAST_TICK_FOUR = 3'h3;
  localparam logic [2:0] LAST_TICK_EIGHT = 3'h7;
  localparam int SEL_Q1_BIT = 31;
  localparam int SEL_Q3_BIT = 29;
  localparam int SEL_Q4_BIT = 28;
  localparam int LINE0_LOW_HI_BIT = 23;
  localparam int LINE0_LOW_LO_BIT = 22;
  localparam int LINE0_HIGH_HI_BIT = 21;
  localparam int LINE0_HIGH_LO_BIT = 20;
  localparam logic [1:0] LINE_DEFAULT = 2'h0;
  localparam logic [1:0] LINE_RESERVED = 2'h1;
  localparam logic [1:0] LINE_LOW = 2'h2;
  localparam logic [1:0] LINE_HIGH = 2'h3;
  localparam logic [5:0] PTR_RESET = 6'h00;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [1:0] CMD_RESET = 2'h0;
  localparam logic LINE_DEFAULT_RESET = 1'b1;
  localparam logic [3:0] SELECT_IDLE = 4'hF;
  localparam logic [2:0] TICK_RESET = 3'h0;
endpackage

// File: rtl/pattern_sequencer.sv
// Pattern sequencer: RAM load and read-back, and chip-select timing generation.
`timescale 1ns/1ps
`default_nettype none
module pattern_sequencer (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic mode_write_in,
  input wire logic [1:0] mode_command_in,
  input wire logic [sequencer_pkg::PTR_WIDTH-1:0] mode_pointer_in,
  input wire logic mode_line_zero_in,
  input wire logic transfer_write_in,
  input wire logic [sequencer_pkg::RAM_WIDTH-1:0] transfer_data_in,
  input wire logic [1:0] bus_divider_field_in,
  input wire logic [sequencer_pkg::NUM_BANKS-1:0][sequencer_pkg::BANK_WIDTH-1:0] bank_base_in,
  input wire logic [sequencer_pkg::NUM_BANKS-1:0][sequencer_pkg::BANK_WIDTH-1:0] bank_mask_in,
  input wire logic [sequencer_pkg::NUM_BANKS-1:0] bank_assigned_in,
  input wire logic txn_valid_in,
  input wire logic txn_write_in,
  input wire logic [sequencer_pkg::ADDR_WIDTH-1:0] txn_addr_in,
  output logic [1:0] machine_command_field_out,
  output logic [sequencer_pkg::PTR_WIDTH-1:0] ram_word_pointer_out,
  output logic [sequencer_pkg::RAM_WIDTH-1:0] ram_word_transfer_reg_out,
  output logic [sequencer_pkg::NUM_BANKS-1:0] local_chip_select_n_out,
  output logic general_line_zero_out,
  output logic busy_out,
  output logic txn_done_out
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STORE,
    ST_FETCH,
    ST_LATCH,
    ST_PLAY,
    ST_FINISH
  } fsm_type;

  typedef struct packed {
    fsm_type fsm;
    logic [1:0] cmd;
    logic [sequencer_pkg::PTR_WIDTH-1:0] ptr;
    logic line_default;
    logic [sequencer_pkg::RAM_WIDTH-1:0] xfer;
    logic [sequencer_pkg::RAM_WIDTH-1:0] word;
    logic [sequencer_pkg::NUM_BANKS-1:0] hit;
    logic [1:0] div;
    logic [2:0] tick;
    logic bump;
    logic [sequencer_pkg::NUM_BANKS-1:0] sel_n;
    logic line;
    logic busy;
    logic done;
  } state_type;

  localparam state_type STATE_RESET = '{
    fsm: ST_IDLE,
    cmd: sequencer_pkg::CMD_RESET,
    ptr: sequencer_pkg::PTR_RESET,
    line_default: sequencer_pkg::LINE_DEFAULT_RESET,
    xfer: sequencer_pkg::WORD_RESET,
    word: sequencer_pkg::WORD_RESET,
    hit: '0,
    div: sequencer_pkg::DIV_FOUR,
    tick: sequencer_pkg::TICK_RESET,
    bump: 1'b0,
    sel_n: sequencer_pkg::SELECT_IDLE,
    line: sequencer_pkg::LINE_DEFAULT_RESET,
    busy: 1'b0,
    done: 1'b0
  };

  state_type st_reg;
  state_type st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [sequencer_pkg::NUM_BANKS-1:0] bank_match;
  logic [sequencer_pkg::NUM_BANKS-1:0] bank_hit;
  logic [1:0] quarter;
  logic [2:0] last_tick;
  logic select_bit;
  logic [1:0] line_code;
  logic ram_write;
  logic [sequencer_pkg::RAM_WIDTH-1:0] ram_rdata;

  // The asynchronous reset is released through two flip-flops.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Each bank compares the upper address bits under its mask.
  genvar b;
  generate
    for (b = 0; b < sequencer_pkg::NUM_BANKS; b++) begin : g_bank
      assign bank_match[b] = bank_assigned_in[b] &&
        ((txn_addr_in[sequencer_pkg::ADDR_WIDTH-1 -: sequencer_pkg::BANK_WIDTH] &
          bank_mask_in[b]) == (bank_base_in[b] & bank_mask_in[b]));
    end
  endgenerate

  // Overlapping banks resolve to the lowest index so one select is driven.
  assign bank_hit = bank_match & (~bank_match + sequencer_pkg::NUM_BANKS'(1));

  pattern_store u_store (
    .clk_in(clk_in),
    .write_in(ram_write),
    .addr_in(st_reg.ptr),
    .data_in(st_reg.xfer),
    .data_out(ram_rdata)
  );

  assign ram_write = (st_reg.fsm == ST_STORE);

  // Map the tick inside a bus cycle to its quarter phase.
  always_comb begin
    unique case (st_reg.div)
      sequencer_pkg::DIV_TWO: begin
        quarter = {st_reg.tick[0], 1'b0};
        last_tick = sequencer_pkg::LAST_TICK_TWO;
      end
      sequencer_pkg::DIV_EIGHT: begin
        quarter = st_reg.tick[2:1];
        last_tick = sequencer_pkg::LAST_TICK_EIGHT;
      end
      default: begin
        quarter = st_reg.tick[1:0];
        last_tick = sequencer_pkg::LAST_TICK_FOUR;
      end
    endcase
  end

  assign select_bit = st_reg.word[sequencer_pkg::SEL_Q1_BIT - int'(quarter)];
  assign line_code = quarter[1] ?
    st_reg.word[sequencer_pkg::LINE0_HIGH_HI_BIT:sequencer_pkg::LINE0_HIGH_LO_BIT] :
    st_reg.word[sequencer_pkg::LINE0_LOW_HI_BIT:sequencer_pkg::LINE0_LOW_LO_BIT];

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    unique case (st_reg.fsm)
      ST_IDLE: begin
        if (txn_valid_in && (|bank_hit)) begin
          st_next.hit = bank_hit;
          st_next.div = bus_divider_field_in;
          st_next.tick = sequencer_pkg::TICK_RESET;
          st_next.busy = 1'b1;
          if (st_reg.cmd == sequencer_pkg::CMD_WRITE) begin
            st_next.fsm = txn_write_in ? ST_STORE : ST_FINISH;
          end else if (st_reg.cmd == sequencer_pkg::CMD_READ) begin
            st_next.fsm = txn_write_in ? ST_FINISH : ST_FETCH;
          end else begin
            st_next.fsm = ST_FETCH;
          end
        end else begin
          if (mode_write_in) begin
            st_next.cmd = mode_command_in;
            st_next.ptr = mode_pointer_in;
            st_next.line_default = mode_line_zero_in;
          end
          if (transfer_write_in) begin
            st_next.xfer = transfer_data_in;
          end
        end
        st_next.line = st_next.line_default;
      end
      ST_STORE: begin
        st_next.bump = 1'b1;
        st_next.fsm = ST_FINISH;
      end
      ST_FETCH: begin
        st_next.fsm = ST_LATCH;
      end
      ST_LATCH: begin
        if (st_reg.cmd == sequencer_pkg::CMD_READ) begin
          st_next.xfer = ram_rdata;
          st_next.bump = 1'b1;
          st_next.fsm = ST_FINISH;
        end else begin
          st_next.word = ram_rdata;
          st_next.fsm = ST_PLAY;
        end
      end
      ST_PLAY: begin
        st_next.sel_n = (~st_reg.hit) |
          {sequencer_pkg::NUM_BANKS{select_bit}};
        unique case (line_code)
          sequencer_pkg::LINE_LOW: st_next.line = 1'b0;
          sequencer_pkg::LINE_HIGH: st_next.line = 1'b1;
          default: st_next.line = st_reg.line_default;
        endcase
        st_next.tick = st_reg.tick + 3'h1;
        if (st_reg.tick == last_tick) begin
          st_next.fsm = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (st_reg.bump) begin
          st_next.ptr = st_reg.ptr + sequencer_pkg::PTR_WIDTH'(1);
        end
        st_next.bump = 1'b0;
        st_next.sel_n = sequencer_pkg::SELECT_IDLE;
        st_next.line = st_reg.line_default;
        st_next.done = 1'b1;
        st_next.busy = 1'b0;
        st_next.fsm = ST_IDLE;
      end
      default: begin
        st_next = STATE_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign machine_command_field_out = st_reg.cmd;
  assign ram_word_pointer_out = st_reg.ptr;
  assign ram_word_transfer_reg_out = st_reg.xfer;
  assign local_chip_select_n_out = st_reg.sel_n;
  assign general_line_zero_out = st_reg.line;
  assign busy_out = st_reg.busy;
  assign txn_done_out = st_reg.done;

  // Checks on the sequencing and the waveforms.
  a_store_copies_word: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_IDLE && txn_valid_in && (|bank_hit) && txn_write_in &&
     st_reg.cmd == sequencer_pkg::CMD_WRITE)
    |=> (ram_write && u_store.data_in == $past(st_reg.xfer) &&
         u_store.addr_in == $past(st_reg.ptr)))
    else $error("dummy write did not store the transfer word");

  a_read_loads_word: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_LATCH && st_reg.cmd == sequencer_pkg::CMD_READ)
    |=> ram_word_transfer_reg_out == $past(ram_rdata))
    else $error("dummy read did not load the transfer register");

  a_pointer_then_done: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_FINISH && st_reg.bump)
    |=> (txn_done_out &&
         ram_word_pointer_out == $past(st_reg.ptr) + sequencer_pkg::PTR_WIDTH'(1)))
    else $error("pointer did not advance with completion");

  a_access_done_bound: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_IDLE && txn_valid_in && (|bank_hit) && !txn_write_in &&
     st_reg.cmd == sequencer_pkg::CMD_READ)
    |-> ##4 (txn_done_out && busy_out == 1'b0))
    else $error("RAM read access did not complete in four cycles");

  a_access_lines_quiet: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (busy_out && (st_reg.cmd == sequencer_pkg::CMD_WRITE ||
                  st_reg.cmd == sequencer_pkg::CMD_READ))
    |-> (local_chip_select_n_out == sequencer_pkg::SELECT_IDLE &&
         general_line_zero_out == st_reg.line_default))
    else $error("RAM access moved a control line");

  a_one_select_low: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    $onehot0(~local_chip_select_n_out) &&
    ((~local_chip_select_n_out & ~st_reg.hit) == '0))
    else $error("a select outside the matching bank is active");

  a_half_phase_two: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_PLAY && st_reg.div == sequencer_pkg::DIV_TWO &&
     st_reg.tick == 3'h0)
    |=> (local_chip_select_n_out ==
         ((~st_reg.hit) | {sequencer_pkg::NUM_BANKS{st_reg.word[sequencer_pkg::SEL_Q1_BIT]}}))
    ##1 (local_chip_select_n_out ==
         ((~st_reg.hit) | {sequencer_pkg::NUM_BANKS{st_reg.word[sequencer_pkg::SEL_Q3_BIT]}}))
    ##1 (st_reg.fsm == ST_IDLE))
    else $error("divide-by-two waveform is wrong");

  a_quarter_three_four: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_PLAY && st_reg.div == sequencer_pkg::DIV_FOUR &&
     st_reg.tick == 3'h2)
    |=> (local_chip_select_n_out ==
         ((~st_reg.hit) | {sequencer_pkg::NUM_BANKS{st_reg.word[sequencer_pkg::SEL_Q3_BIT]}})))
    else $error("third quarter select is wrong");

  a_eighth_holds_last: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_PLAY && st_reg.div == sequencer_pkg::DIV_EIGHT &&
     st_reg.tick == 3'h6)
    |=> (local_chip_select_n_out ==
         ((~st_reg.hit) | {sequencer_pkg::NUM_BANKS{st_reg.word[sequencer_pkg::SEL_Q4_BIT]}}))
    [*2])
    else $error("fourth quarter does not span two cycles");

  a_cycle_length_four: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_PLAY && st_reg.div == sequencer_pkg::DIV_FOUR &&
     st_reg.tick == 3'h0)
    |-> (st_reg.fsm == ST_PLAY) [*4] ##1 (st_reg.fsm == ST_FINISH))
    else $error("bus cycle does not last four ticks");

  a_line_zero_first: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st_reg.fsm == ST_PLAY && st_reg.tick == 3'h0)
    |=> (general_line_zero_out ==
         ($past(line_code) == sequencer_pkg::LINE_LOW ? 1'b0 :
          $past(line_code) == sequencer_pkg::LINE_HIGH ? 1'b1 :
          st_reg.line_default)))
    else $error("line zero does not follow the first-half code");
endmodule
`default_nettype wire

// File: rtl/pattern_store.sv
// Pattern word store: one synchronous write port and a registered read.
`timescale 1ns/1ps
`default_nettype none
module pattern_store (
  input wire logic clk_in,
  input wire logic write_in,
  input wire logic [sequencer_pkg::PTR_WIDTH-1:0] addr_in,
  input wire logic [sequencer_pkg::RAM_WIDTH-1:0] data_in,
  output logic [sequencer_pkg::RAM_WIDTH-1:0] data_out
);
  logic [sequencer_pkg::RAM_WIDTH-1:0] mem_reg [0:sequencer_pkg::RAM_DEPTH-1];

  // A read in the cycle of a write returns the old word.
  always_ff @(posedge clk_in) begin
    if (write_in) begin
      mem_reg[addr_in] <= data_in;
    end
    data_out <= mem_reg[addr_in];
  end
endmodule
`default_nettype wire
